// ===== src/sadc_pkg.sv
/*
  types shared by the converter control block.
  assumes: compiled before the design modules.
*/
`include "sadc_regs.svh"

package sadc_pkg;

  // successive-approximation sequencer states
  typedef enum logic [1:0] {
    SADC_IDLE   = 2'b00,
    SADC_SAMPLE = 2'b01,
    SADC_CONV   = 2'b10
  } sadc_state_type;

endpackage : sadc_pkg

// ===== src/sadc_regs.svh
/*
  register offsets, field positions, reset values and timing counts
  of the successive-approximation converter control block.
  assumes: included by bare name from the package and the bench.
*/
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// register byte offsets on the register bus
`define SADC_ADDR_W        4
`define SADC_OFS_CSR       4'h0
`define SADC_OFS_RES_HIGH  4'h4
`define SADC_OFS_RES_LOW   4'h8

// control/status register fields
`define SADC_CSR_DONE      7
`define SADC_CSR_SPEED     6
`define SADC_CSR_ON        5
`define SADC_CSR_SEL_HI    2
`define SADC_CSR_SEL_LO    0

// result low register fields
`define SADC_LOW_SLOW      3
`define SADC_LOW_D_HI      1

// widths, reset values and codes
`define SADC_RES_W         10
`define SADC_SEL_W         3
`define SADC_BIT_W         4
`define SADC_RESET_BYTE    8'h00
`define SADC_RESET_RES     10'h000
`define SADC_MSB_TRIAL     10'h200
`define SADC_MSB_INDEX     4'h9
`define SADC_SAMPLE_TICKS  3'h4
`define SADC_SAMPLE_LAST   3'h0

// converter clock divider limits (count of cpu cycles minus one)
`define SADC_DIV_W         2
`define SADC_DIV_FULL      2'h0
`define SADC_DIV_HALF      2'h1
`define SADC_DIV_QUARTER   2'h3

// bus answers
`define SADC_RESP_OKAY     2'h0
`define SADC_RESP_SLVERR   2'h2

`endif

// ===== src/sadc_sar.sv
/*
  successive-approximation sequencer: samples the chosen input, then
  decides ten bits msb first from the comparator, and repeats while on.
  assumes: comparator answer is valid one converter tick after trial_code
  changes; tick is a one-cycle pulse from the clock divider, held high every cycle with the fast bit set and the slow bit clear.
*/
`timescale 1ns/1ps

module sadc_sar
  import sadc_pkg::*;
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    run,
  input  wire logic                    tick,
  input  wire logic [`SADC_SEL_W-1:0]  select_in,
  input  wire logic                    cmp_above,
  output logic                         sample_hold,
  output logic      [`SADC_SEL_W-1:0]  channel_out,
  output logic      [`SADC_RES_W-1:0]  trial_code,
  output logic                         done,
  output logic      [`SADC_RES_W-1:0]  result
);

  sadc_state_type            state_r, state_nxt;
  logic [2:0]                samp_r, samp_nxt;
  logic [`SADC_BIT_W-1:0]    bit_r, bit_nxt;
  logic [`SADC_RES_W-1:0]    code_r, code_nxt;
  logic [`SADC_RES_W-1:0]    trial_r, trial_nxt;
  logic [`SADC_SEL_W-1:0]    chan_r, chan_nxt;
  logic [`SADC_RES_W-1:0]    res_r, res_nxt;
  logic                      done_r, done_nxt;

  // next-state of the sequencer
  always_comb begin
    state_nxt = state_r;
    samp_nxt  = samp_r;
    bit_nxt   = bit_r;
    code_nxt  = code_r;
    trial_nxt = trial_r;
    chan_nxt  = chan_r;
    res_nxt   = res_r;
    done_nxt  = 1'b0;
    if (!run) begin
      state_nxt = SADC_IDLE;
      trial_nxt = `SADC_RESET_RES;
    end else if (tick) begin
      unique case (state_r)
        SADC_IDLE: begin
          chan_nxt  = select_in;
          samp_nxt  = `SADC_SAMPLE_TICKS;
          state_nxt = SADC_SAMPLE;
        end
        SADC_SAMPLE: begin
          if (samp_r == `SADC_SAMPLE_LAST) begin
            state_nxt = SADC_CONV;
            bit_nxt   = `SADC_MSB_INDEX;
            code_nxt  = `SADC_RESET_RES;
            trial_nxt = `SADC_MSB_TRIAL;
          end else begin
            samp_nxt = samp_r - 3'h1;
          end
        end
        SADC_CONV: begin
          // keep bit when input at or above trial
          code_nxt  = cmp_above ? trial_r : code_r;
          if (bit_r == `SADC_BIT_W'(0)) begin
            // restart at once, back to back
            res_nxt   = code_nxt;
            done_nxt  = 1'b1;
            chan_nxt  = select_in;
            samp_nxt  = `SADC_SAMPLE_TICKS;
            trial_nxt = `SADC_RESET_RES;
            state_nxt = SADC_SAMPLE;
          end else begin
            bit_nxt   = bit_r - `SADC_BIT_W'(1);
            // trial xor kept code isolates the bit under test, so kept bits never shift
            trial_nxt = code_nxt | ((trial_r ^ code_r) >> 1);
          end
        end
        default: state_nxt = SADC_IDLE;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SADC_IDLE;
      samp_r  <= `SADC_SAMPLE_LAST;
      bit_r   <= `SADC_MSB_INDEX;
      code_r  <= `SADC_RESET_RES;
      trial_r <= `SADC_RESET_RES;
      chan_r  <= '0;
      res_r   <= `SADC_RESET_RES;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      samp_r  <= samp_nxt;
      bit_r   <= bit_nxt;
      code_r  <= code_nxt;
      trial_r <= trial_nxt;
      chan_r  <= chan_nxt;
      res_r   <= res_nxt;
      done_r  <= done_nxt;
    end
  end

  // outputs to the converter core and the register side
  assign sample_hold = (state_r == SADC_SAMPLE);
  assign channel_out = chan_r;
  assign trial_code  = trial_r;
  assign done        = done_r;
  assign result      = res_r;

  // checks of the sequencer
  off_goes_idle_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !run |=> state_r == SADC_IDLE)
    else $error("sequencer did not stop when switched off");
  done_from_conv_a : assert property (@(posedge aclk) disable iff (!aresetn)
    done |-> $past(state_r) == SADC_CONV && $past(tick))
    else $error("completion pulse without a final bit decision");
  chan_stable_a : assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == SADC_CONV && state_nxt == SADC_CONV |=> $stable(chan_r))
    else $error("channel changed during a conversion");
  cover_done_c : cover property (@(posedge aclk) disable iff (!aresetn) done);

endmodule : sadc_sar

// ===== src/sadc_top.sv
/*
  control block of a 10-bit successive-approximation converter with
  seven multiplexed inputs: register file on axi4-lite, clock divider,
  sequencer instance, completion flag and result registers.
  assumes: the analog core outside drives cmp_above for the trial code
  and the selected channel; halt_mode and wait_mode come from the
  power manager and are synchronous to aclk.
*/
`timescale 1ns/1ps

// Function
// - ten-bit successive approximation over seven multiplexed inputs with sample/hold.
// - results held in high/low register pair; one control/status register.
// - three-bit input select field chooses the converted channel.
// - converter-on starts continuous back-to-back conversion.
// - each completion sets done flag and loads both result registers.
// - reading high result clears done flag; reading low does not.
// - input above upper reference gives 0xff/0x03, no overflow flag.
// - input below lower reference gives zero in both result registers.
// - result codes are monotonic with the input.
// - clearing converter-on powers the converter off.
// - wait mode leaves conversion unchanged.
// - halt disables converter; software waits stabilisation after wakeup.
// - analog use of a pin keeps its digital input readable.
// - select codes 000 to 110 map to inputs 0 to 6.
// - high holds result bits 9..2, low holds bits 1..0.
// - converter clock: cpu/2, cpu with fast bit, cpu/4 with slow bit.
module sadc_top
  import sadc_pkg::*;
(
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [`SADC_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  output logic      [1:0]               s_axi_bresp,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  input  wire logic [`SADC_ADDR_W-1:0]  s_axi_araddr,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  output logic      [31:0]              s_axi_rdata,
  output logic      [1:0]               s_axi_rresp,
  input  wire logic                     halt_mode,
  input  wire logic                     wait_mode,
  input  wire logic                     cmp_above,
  output logic                          converter_power,
  output logic                          sample_hold,
  output logic      [`SADC_SEL_W-1:0]   analog_input_select,
  output logic      [`SADC_RES_W-1:0]   trial_code
);

  // software-visible state
  logic                     done_r, done_nxt;
  logic                     on_r, on_nxt;
  logic                     speed_r, speed_nxt;
  logic                     slow_r, slow_nxt;
  logic [`SADC_SEL_W-1:0]   sel_r, sel_nxt;
  logic [`SADC_RES_W-1:0]   res_r, res_nxt;
  // bus slave state
  logic                     awh_r, awh_nxt;
  logic [`SADC_ADDR_W-1:0]  awa_r, awa_nxt;
  logic                     wh_r, wh_nxt;
  logic [7:0]               wd_r, wd_nxt;
  logic                     ws_r, ws_nxt;
  logic                     bv_r, bv_nxt;
  logic [1:0]               br_r, br_nxt;
  logic                     rv_r, rv_nxt;
  logic [31:0]              rd_r, rd_nxt;
  logic [1:0]               rr_r, rr_nxt;
  // divider state
  logic [`SADC_DIV_W-1:0]   div_r, div_nxt;
  logic [`SADC_DIV_W-1:0]   div_lim;
  logic                     tick;
  // sequencer wiring
  logic                     run;
  logic                     sar_done;
  logic [`SADC_RES_W-1:0]   sar_result;
  logic                     wr_fire, rd_fire;
  logic                     rd_high;
  logic [7:0]               rd_byte;

  assign run             = on_r && !halt_mode;
  assign converter_power = run;

  // divider limit from slow and fast bits
  always_comb begin
    if (slow_r)       div_lim = `SADC_DIV_QUARTER;
    else if (speed_r) div_lim = `SADC_DIV_FULL;
    else              div_lim = `SADC_DIV_HALF;
  end
  assign tick = (div_r >= div_lim);

  always_comb begin
    div_nxt = tick ? '0 : div_r + `SADC_DIV_W'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) div_r <= '0;
    else          div_r <= div_nxt;
  end

  // sequencer latches select at each conversion start and drives the input mux
  sadc_sar u_sar (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .run         (run),
    .tick        (tick),
    .select_in   (sel_r),
    .cmp_above   (cmp_above),
    .sample_hold (sample_hold),
    .channel_out (analog_input_select),
    .trial_code  (trial_code),
    .done        (sar_done),
    .result      (sar_result)
  );

  // bus handshakes; a write completes once both halves are held
  assign s_axi_awready = !awh_r && !bv_r;
  assign s_axi_wready  = !wh_r && !bv_r;
  assign s_axi_arready = !rv_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;
  assign wr_fire       = awh_r && wh_r && !bv_r;
  assign rd_fire       = s_axi_arvalid && !rv_r;
  assign rd_high       = rd_fire && (s_axi_araddr == `SADC_OFS_RES_HIGH);

  // one status and two result registers, reserved bits read zero
  always_comb begin
    rd_byte = `SADC_RESET_BYTE;
    unique case (s_axi_araddr)
      `SADC_OFS_CSR: begin
        rd_byte[`SADC_CSR_DONE]  = done_r;
        rd_byte[`SADC_CSR_SPEED] = speed_r;
        rd_byte[`SADC_CSR_ON]    = on_r;
        rd_byte[`SADC_CSR_SEL_HI:`SADC_CSR_SEL_LO] = sel_r;
      end
      `SADC_OFS_RES_HIGH: rd_byte = res_r[`SADC_RES_W-1:2];
      `SADC_OFS_RES_LOW: begin
        rd_byte[`SADC_LOW_SLOW] = slow_r;
        rd_byte[`SADC_LOW_D_HI:0] = res_r[1:0];
      end
      default: rd_byte = `SADC_RESET_BYTE;
    endcase
  end

  // next values of bus slave and registers
  always_comb begin
    awh_nxt = awh_r;
    awa_nxt = awa_r;
    wh_nxt  = wh_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    rv_nxt  = rv_r;
    rd_nxt  = rd_r;
    rr_nxt  = rr_r;
    on_nxt    = on_r;
    speed_nxt = speed_r;
    slow_nxt  = slow_r;
    sel_nxt   = sel_r;
    res_nxt   = res_r;
    done_nxt  = done_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awh_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wh_nxt = 1'b1;
      wd_nxt = s_axi_wdata[7:0];
      ws_nxt = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = `SADC_RESP_OKAY;
      unique case (awa_r)
        `SADC_OFS_CSR: begin
          if (ws_r) begin
            speed_nxt = wd_r[`SADC_CSR_SPEED];
            on_nxt    = wd_r[`SADC_CSR_ON];
            sel_nxt   = wd_r[`SADC_CSR_SEL_HI:`SADC_CSR_SEL_LO];
          end
        end
        `SADC_OFS_RES_LOW: if (ws_r) slow_nxt = wd_r[`SADC_LOW_SLOW];
        `SADC_OFS_RES_HIGH: br_nxt = `SADC_RESP_OKAY;
        default: br_nxt = `SADC_RESP_SLVERR;
      endcase
    end else if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (rd_fire) begin
      rv_nxt = 1'b1;
      rd_nxt = {24'h000000, rd_byte};
      rr_nxt = (s_axi_araddr == `SADC_OFS_CSR || s_axi_araddr == `SADC_OFS_RES_HIGH ||
                s_axi_araddr == `SADC_OFS_RES_LOW) ? `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
    end else if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    // high read clears, completion in same cycle wins
    if (rd_high) done_nxt = 1'b0;
    if (sar_done) begin
      // flag and results, full scale and zero pass through
      done_nxt = 1'b1;
      res_nxt  = sar_result;
    end
  end

  // reset values; no interrupt output exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_r   <= 1'b0;
      awa_r   <= '0;
      wh_r    <= 1'b0;
      wd_r    <= `SADC_RESET_BYTE;
      ws_r    <= 1'b0;
      bv_r    <= 1'b0;
      br_r    <= `SADC_RESP_OKAY;
      rv_r    <= 1'b0;
      rd_r    <= '0;
      rr_r    <= `SADC_RESP_OKAY;
      on_r    <= 1'b0;
      speed_r <= 1'b0;
      slow_r  <= 1'b0;
      sel_r   <= '0;
      res_r   <= `SADC_RESET_RES;
      done_r  <= 1'b0;
    end else begin
      awh_r   <= awh_nxt;
      awa_r   <= awa_nxt;
      wh_r    <= wh_nxt;
      wd_r    <= wd_nxt;
      ws_r    <= ws_nxt;
      bv_r    <= bv_nxt;
      br_r    <= br_nxt;
      rv_r    <= rv_nxt;
      rd_r    <= rd_nxt;
      rr_r    <= rr_nxt;
      on_r    <= on_nxt;
      speed_r <= speed_nxt;
      slow_r  <= slow_nxt;
      sel_r   <= sel_nxt;
      res_r   <= res_nxt;
      done_r  <= done_nxt;
    end
  end

  // no pin control here: digital input path stays untouched
  // wait_mode is deliberately not used by any logic
  logic wait_seen;
  assign wait_seen = wait_mode;

  // checks of the register side
  done_sets_a : assert property (@(posedge aclk) disable iff (!aresetn)
    sar_done |=> done_r && res_r == $past(sar_result))
    else $error("completion did not set flag and result");
  high_clears_a : assert property (@(posedge aclk) disable iff (!aresetn)
    rd_high && !sar_done |=> !done_r)
    else $error("high result read did not clear done flag");
  low_keeps_a : assert property (@(posedge aclk) disable iff (!aresetn)
    done_r && !rd_high |=> done_r)
    else $error("done flag lost without a high read");
  halt_off_a : assert property (@(posedge aclk) disable iff (!aresetn)
    halt_mode |-> !converter_power ##1 !sar_done)
    else $error("converter running in halt");
  quarter_div_a : assert property (@(posedge aclk) disable iff (!aresetn)
    slow_r && tick ##1 slow_r |-> !tick ##1 (!tick || !$stable(slow_r)))
    else $error("slow divider ticked too soon");
  read_answer_a : assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  write_answer_a : assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  off_idle_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !on_r [*2] |-> !sar_done)
    else $error("conversion finished while switched off");
  cover_high_c : cover property (@(posedge aclk) disable iff (!aresetn) rd_high && done_r);
  cover_race_c : cover property (@(posedge aclk) disable iff (!aresetn) rd_high && sar_done);
  cover_full_c : cover property (@(posedge aclk) disable iff (!aresetn)
    sar_done && sar_result == 10'h3ff);

endmodule : sadc_top

// ===== verification/sadc_analog_model.sv
/*
  behavioural analog core: seven input levels, sample/hold, comparator.
  assumes: levels come from the bench as codes, above 10'h3ff meaning over
  the upper reference; power, sample_hold, channel and trial come from the block.
*/
`timescale 1ns/1ps

module sadc_analog_model (
  input  wire logic              aclk,
  input  wire logic [6:0][10:0]  levels,
  input  wire logic              converter_power,
  input  wire logic              sample_hold,
  input  wire logic [2:0]        analog_input_select,
  input  wire logic [9:0]        trial_code,
  output logic                   cmp_above
);
  logic [10:0] held_r;
  logic        noise_r = 1'b0;

  always_ff @(posedge aclk) begin
    if (sample_hold && analog_input_select != 3'h7) begin
      held_r <= levels[analog_input_select];
    end
    noise_r <= ~noise_r;
  end

  assign cmp_above = converter_power ? ({1'b0, trial_code} <= held_r) : noise_r;
endmodule : sadc_analog_model

// ===== verification/tb_sadc_top.sv
/*
  self-checking bench of the converter control block over axi4-lite.
  assumes: sadc_analog_model stands in for the analog core and pins.
*/
`timescale 1ns/1ps
`include "sadc_regs.svh"

module tb_sadc_top;
  logic              aclk = 1'b0;
  logic              aresetn;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [3:0]        s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0]       s_axi_wdata, s_axi_rdata, d;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              halt_mode, wait_mode, cmp_above, converter_power, sample_hold;
  logic [2:0]        analog_input_select;
  logic [9:0]        trial_code, e;
  logic [6:0][10:0]  lv = {11'h200, 11'h001, 11'h3fe, 11'h2aa, 11'h155, 11'h7ff, 11'h000};
  int                err_total = 0;
  int                checks = 0;
  int                i, c;

  // clock of 4 ns
  always #2 aclk = ~aclk;

  sadc_top sadc_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .halt_mode(halt_mode),
    .wait_mode(wait_mode), .cmp_above(cmp_above), .converter_power(converter_power),
    .sample_hold(sample_hold), .analog_input_select(analog_input_select),
    .trial_code(trial_code));

  sadc_analog_model sadc_analog_model_i (.aclk(aclk), .levels(lv),
    .converter_power(converter_power), .sample_hold(sample_hold),
    .analog_input_select(analog_input_select), .trial_code(trial_code),
    .cmp_above(cmp_above));

  // verdict and end of run
  task automatic complete_run();
    if (err_total == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : complete_run

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // a wait that ran out
  task automatic hang();
    err_total++;
    complete_run();
  endtask : hang

  // one write; ready sampled at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    int   n;
    b_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 100 && !b_t; n++) begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    if (!b_t) hang();
  endtask : wr

  // one read
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] resp);
    logic ar_t, r_t;
    int   n;
    r_t = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 100 && !r_t; n++) begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end
    if (!r_t) hang();
  endtask : rd

  // poll the done flag
  task automatic wait_done();
    logic [31:0] v;
    logic [1:0]  q;
    int          n;
    v = 32'h0;
    for (n = 0; n < 200 && v[7] !== 1'b1; n++) rd(`SADC_OFS_CSR, v, q);
    if (v[7] !== 1'b1) hang();
  endtask : wait_done

  // wait until sample_hold shows a level
  task automatic wait_level(input logic lvl);
    int n;
    for (n = 0; n < 400 && sample_hold !== lvl; n++) @(negedge aclk);
    if (sample_hold !== lvl) hang();
  endtask : wait_level

  // cycles between the second and third conversion start
  task automatic period(output int p);
    int   n, k, cnt;
    logic prev;
    k = 0;
    cnt = 0;
    prev = 1'b1;
    for (n = 0; n < 600 && k < 3; n++) begin
      @(negedge aclk);
      cnt++;
      if (sample_hold === 1'b1 && !prev) begin
        if (k == 2) p = cnt;
        cnt = 0;
        k++;
      end
      prev = sample_hold;
    end
    if (k < 3) hang();
    @(posedge aclk);
  endtask : period

  // main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, halt_mode, wait_mode} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 12'h0;
    s_axi_wdata = 32'h0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < 3; i++) begin
      rd(4 * i, d, r);
      check(d, 32'h0);
      check(r, 32'h0);
    end
    rd(4'hc, d, r);
    check(d, 32'h0);
    check(r, 32'h2);
    wr(4'hc, 32'hff, 4'h1, r);
    check(r, 2'h2);
    wr(`SADC_OFS_CSR, 32'h27, 4'h0, r);
    rd(`SADC_OFS_CSR, d, r);
    check(d, 32'h0);
    wr(`SADC_OFS_RES_HIGH, 32'hff, 4'h1, r);
    check(r, 32'h0);
    rd(`SADC_OFS_RES_HIGH, d, r);
    check(d, 32'h0);
    for (i = 0; i < 7; i++) begin
      e = (lv[i] > 11'h3ff) ? 10'h3ff : lv[i][9:0];
      rd(`SADC_OFS_RES_HIGH, d, r);
      wr(`SADC_OFS_CSR, 32'h20 | i, 4'h1, r);
      wait_done();
      check(analog_input_select, i);
      if (i != 4) begin
        rd(`SADC_OFS_RES_LOW, d, r);
        check(d, e[1:0]);
        rd(`SADC_OFS_CSR, d, r);
        check(d[7], 1'b1);
      end
      rd(`SADC_OFS_RES_HIGH, d, r);
      check(d, e[9:2]);
      rd(`SADC_OFS_CSR, d, r);
      check(d, 32'h20 | i);
      wr(`SADC_OFS_CSR, 32'h0, 4'h1, r);
      repeat (2) @(posedge aclk);
      check({converter_power, sample_hold}, 2'h0);
    end
    wait_mode <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wr(`SADC_OFS_RES_LOW, {i[1], 3'h0}, 4'h1, r);
      wr(`SADC_OFS_CSR, 32'h22 | (i[0] << 6), 4'h1, r);
      period(c);
      check(c, 15 * (i[1] ? 4 : (i[0] ? 1 : 2)));
      rd(`SADC_OFS_RES_LOW, d, r);
      check(d[3], i[1]);
    end
    wr(`SADC_OFS_RES_LOW, 32'h0, 4'h1, r);
    halt_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    check(converter_power, 1'b0);
    rd(`SADC_OFS_CSR, d, r);
    check(d[5], 1'b1);
    halt_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    check(converter_power, 1'b1);
    wr(`SADC_OFS_CSR, 32'h0, 4'h1, r);
    rd(`SADC_OFS_RES_HIGH, d, r);
    wr(`SADC_OFS_CSR, 32'h22, 4'h1, r);
    wait_level(1'b1);
    wait_level(1'b0);
    @(posedge aclk);
    wr(`SADC_OFS_CSR, 32'h23, 4'h1, r);
    check(analog_input_select, 3'h2);
    wait_done();
    rd(`SADC_OFS_RES_HIGH, d, r);
    check(d, lv[2][9:2]);
    wait_done();
    rd(`SADC_OFS_RES_HIGH, d, r);
    check(d, lv[3][9:2]);
    complete_run();
  end
endmodule : tb_sadc_top
